/* lmc_board_model.sv */
// Behavioural lens motor board answering the controller's byte frames
`include "lmc_cfg.svh"
module lmc_board_model #(
    parameter logic [39:0] VER   = 40'h1122334455,  // Arbitrary value
    parameter logic [47:0] IDENT = 48'h6A7B8C9DAEBF // Arbitrary value
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    input  wire logic       slow_i,
    input  wire logic       mute_i,
    output logic            tx_ready_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic [7:0]      last_code_o,
    output logic [3:0]      last_len_o,
    output logic [7:0]      last_bus_o,
    output logic [7:0]      last_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    lmc_pkg::lmc_setup_t setup_q [1:4];
    logic [7:0]          in_q[$];
    logic [7:0]          out_q[$];
    logic [7:0]          last_q[$];
    logic                phase_q;
    int                  gap_q;

    // Slow mode takes a byte only on every other cycle and answers 20 cycles late
    assign tx_ready_o = !slow_i || phase_q;

    task automatic decode();
        logic [7:0]          m;
        int                  n;
        lmc_pkg::lmc_setup_t s;
        logic [47:0]         v;
        n = in_q.size();
        m = (n > 1) ? in_q[1] : 8'h00;
        last_code_o = in_q[0];
        last_len_o = 4'(n);
        if (mute_i) begin
            out_q = last_q;
            return;
        end
        gap_q = slow_i ? 20 : 0;
        case (in_q[0])
            `LMC_CODE_VERSION, `LMC_CODE_IDENT: if (n == 1) begin
                v = (in_q[0] == `LMC_CODE_IDENT) ? IDENT : {VER, 8'h00};
                out_q.push_back(in_q[0]);
                for (int i = 5; i >= 0; i--)
                    if (i > 0 || in_q[0] == `LMC_CODE_IDENT)
                        out_q.push_back(v[8*i +: 8]);
                out_q.push_back(`LMC_CR);
            end
            `LMC_CODE_SETUP_RD: if (n == 2 && m >= 1 && m <= 4) begin
                out_q.push_back(in_q[0]);
                out_q.push_back(m);
                for (int i = 8; i >= 0; i--)
                    out_q.push_back(setup_q[m[2:0]][8*i +: 8]);
                out_q.push_back(`LMC_CR);
            end
            `LMC_CODE_SETUP_WR: if (n == 11) begin
                for (int i = 0; i < 9; i++)
                    s[71-8*i -: 8] = in_q[2+i];
                if (m >= 1 && m <= 4)
                    setup_q[m[2:0]] = s;
                out_q.push_back(in_q[0]);
                out_q.push_back((m >= 1 && m <= 4) ? 8'h00 : 8'h01);
                out_q.push_back(`LMC_CR);
            end
            `LMC_CODE_BUS: if (n == 2 && m <= 8'h02) begin
                last_bus_o = m;
                out_q.delete();
            end
            `LMC_CODE_ADDR: if (n == 2 && m >= 1 && m <= 8'h7F)
                last_addr_o = m;
            default: ;
        endcase
        if (out_q.size() > 0)
            last_q = out_q;
    endtask

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 1; i <= 4; i++)
                setup_q[i] = {(i == 4) ? 8'h01 : 8'h00, 8'h01, 8'h01,
                              16'(i * 100), 16'h000A, 16'h01F4};
            in_q.delete();
            out_q.delete();
            gap_q = 0;
            phase_q <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
            {last_code_o, last_len_o} = '0;
            last_addr_o = 8'h10;
            last_bus_o = 8'h01;
        end else begin
            phase_q <= !phase_q;
            rx_valid_o <= 1'b0;
            rx_data_o <= ~rx_data_o;
            if (tx_valid_i && tx_ready_o) begin
                if (tx_data_i == `LMC_CR) begin
                    if (in_q.size() > 0 && in_q.size() <= 12)
                        decode();
                    in_q.delete();
                end else
                    in_q.push_back(tx_data_i);
            end
            if (gap_q > 0)
                gap_q--;
            else if (out_q.size() > 0) begin
                rx_data_o <= out_q.pop_front();
                rx_valid_o <= 1'b1;
            end
        end
    end
endmodule

/* lmc_cfg.svh */
// Byte codes, frame lengths and timing counts of the lens motor command link
`ifndef LMC_CFG_SVH
`define LMC_CFG_SVH

`define LMC_CR              8'h0D
`define LMC_CODE_VERSION    8'h76
`define LMC_CODE_IDENT      8'h79
`define LMC_CODE_SETUP_RD   8'h67
`define LMC_CODE_SETUP_WR   8'h63
`define LMC_CODE_BUS        8'h6B
`define LMC_CODE_ADDR       8'h41

`define LMC_MOTOR_FIRST     8'h01
`define LMC_MOTOR_LAST      8'h04
`define LMC_BUS_LAST        8'h02
`define LMC_ADDR_FIRST      7'h01
`define LMC_ADDR_LAST       7'h7F
`define LMC_STATUS_OK       8'h00

// Reply lengths, terminator not counted
`define LMC_LEN_VERSION     4'h6
`define LMC_LEN_IDENT       4'h7
`define LMC_LEN_SETUP_RD    4'hB
`define LMC_LEN_SETUP_WR    4'h2

`define LMC_FRAME_MAX       12
`define LMC_CLK_HZ          10000000
`define LMC_TIMEOUT_MS      10
`define LMC_TIMEOUT_CYC     ((`LMC_CLK_HZ / 1000) * `LMC_TIMEOUT_MS)

`endif

/* lmc_frame_rx.sv */
// Collects reply bytes from the board into one frame up to the terminator
`include "lmc_cfg.svh"

module lmc_frame_rx (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic [7:0]        rx_data_i,
    input  wire logic              rx_valid_i,
    output lmc_pkg::lmc_frame_t    frame_o,
    output logic [3:0]             len_o,
    output logic                   frame_done_o
);

    lmc_pkg::lmc_frame_t frame_reg;
    logic [3:0]          cnt_reg;
    logic [3:0]          len_reg;
    logic                done_reg;
    logic                overrun_reg;

    wire is_term = rx_valid_i && (rx_data_i == `LMC_CR);
    wire room    = cnt_reg < 4'(`LMC_FRAME_MAX);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_reg   <= '0;
            cnt_reg     <= 4'h0;
            len_reg     <= 4'h0;
            done_reg    <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (is_term) begin
                // An overlong frame reports length zero so nothing matches it
                len_reg     <= overrun_reg ? 4'h0 : cnt_reg;
                done_reg    <= 1'b1;
                cnt_reg     <= 4'h0;
                overrun_reg <= 1'b0;
            end else if (rx_valid_i) begin
                if (room) begin
                    frame_reg[cnt_reg] <= rx_data_i;
                    cnt_reg            <= cnt_reg + 4'h1;
                end else begin
                    overrun_reg <= 1'b1;
                end
            end
        end
    end

    assign frame_o      = frame_reg;
    assign len_o        = len_reg;
    assign frame_done_o = done_reg;

endmodule

/* lmc_host.sv */
// Host controller that issues serial commands to a lens motor board
`include "lmc_cfg.svh"

module lmc_host #(
    parameter int unsigned TIMEOUT_CYC = `LMC_TIMEOUT_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic              cmd_valid_i,
    input  lmc_pkg::lmc_cmd_t      cmd_i,
    output logic                   cmd_ready_o,
    output logic                   done_o,
    output logic                   err_o,
    output logic [39:0]            version_o,
    output logic [47:0]            board_identity_byte_o,
    output lmc_pkg::lmc_setup_t    setup_o,
    output logic [7:0]             wr_status_o,
    input  wire logic [7:0]        speed_motor_i,
    input  wire logic [15:0]       speed_i,
    output logic                   speed_ok_o,
    output logic [7:0]             tx_data_o,
    output logic                   tx_valid_o,
    input  wire logic              tx_ready_i,
    input  wire logic [7:0]        rx_data_i,
    input  wire logic              rx_valid_i
);

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} lmc_state_t;

    function automatic logic sel_ok(input logic [7:0] s);
        sel_ok = (s >= `LMC_MOTOR_FIRST) && (s <= `LMC_MOTOR_LAST);
    endfunction

    function automatic logic [1:0] sel_idx(input logic [7:0] s);
        sel_idx = 2'(s - `LMC_MOTOR_FIRST);
    endfunction

    lmc_state_t          state_reg;
    lmc_pkg::lmc_frame_t tx_buf_reg;
    logic [3:0]          tx_last_reg;
    logic [3:0]          tx_idx_reg;
    logic [7:0]          tx_data_reg;
    logic                tx_valid_reg;
    logic                expect_reg;
    logic [7:0]          exp_code_reg;
    logic [3:0]          exp_len_reg;
    logic [7:0]          exp_motor_reg;
    logic [31:0]         wait_cnt_reg;
    logic                done_reg;
    logic                err_reg;
    logic                ready_reg;
    logic [39:0]         version_reg;
    logic [47:0]         ident_reg;
    lmc_pkg::lmc_setup_t setup_reg;
    logic [7:0]          wr_status_reg;
    logic [15:0]         min_reg [4];
    logic [15:0]         max_reg [4];
    logic                speed_ok_reg;

    lmc_pkg::lmc_frame_t rx_frame;
    logic [3:0]          rx_len;
    logic                rx_done;

    lmc_frame_rx u_rx (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .rx_data_i    (rx_data_i),
        .rx_valid_i   (rx_valid_i),
        .frame_o      (rx_frame),
        .len_o        (rx_len),
        .frame_done_o (rx_done)
    );

    // Command frame assembly and parameter checks
    lmc_pkg::lmc_frame_t build_frame;
    logic [3:0]          build_last;
    logic [7:0]          build_code;
    logic [3:0]          build_len;
    logic                build_reply;
    logic                build_ok;

    always_comb begin
        build_frame = '0;
        build_last  = 4'h1;
        build_code  = 8'h00;
        build_len   = 4'h0;
        build_reply = 1'b1;
        build_ok    = 1'b1;
        case (cmd_i.op)
            lmc_pkg::LMC_OP_VERSION: begin
                build_frame[0] = `LMC_CODE_VERSION;
                build_frame[1] = `LMC_CR;
                build_code     = `LMC_CODE_VERSION;
                build_len      = `LMC_LEN_VERSION;
            end
            lmc_pkg::LMC_OP_IDENT: begin
                build_frame[0] = `LMC_CODE_IDENT;
                build_frame[1] = `LMC_CR;
                build_code     = `LMC_CODE_IDENT;
                build_len      = `LMC_LEN_IDENT;
            end
            lmc_pkg::LMC_OP_SETUP_RD: begin
                build_frame[0] = `LMC_CODE_SETUP_RD;
                build_frame[1] = cmd_i.motor;
                build_frame[2] = `LMC_CR;
                build_last     = 4'h2;
                build_code     = `LMC_CODE_SETUP_RD;
                build_len      = `LMC_LEN_SETUP_RD;
                build_ok       = sel_ok(cmd_i.motor);
            end
            lmc_pkg::LMC_OP_SETUP_WR: begin
                // Bad selectors still go out: the board answers them
                build_frame[0]  = `LMC_CODE_SETUP_WR;
                build_frame[1]  = cmd_i.motor;
                build_frame[2]  = cmd_i.setup.motor_type;
                build_frame[3]  = cmd_i.setup.left_stop;
                build_frame[4]  = cmd_i.setup.right_stop;
                build_frame[5]  = cmd_i.setup.steps[15:8];
                build_frame[6]  = cmd_i.setup.steps[7:0];
                build_frame[7]  = cmd_i.setup.speed_min[15:8];
                build_frame[8]  = cmd_i.setup.speed_min[7:0];
                build_frame[9]  = cmd_i.setup.speed_max[15:8];
                build_frame[10] = cmd_i.setup.speed_max[7:0];
                build_frame[11] = `LMC_CR;
                build_last      = 4'hB;
                build_code      = `LMC_CODE_SETUP_WR;
                build_len       = `LMC_LEN_SETUP_WR;
            end
            lmc_pkg::LMC_OP_BUS: begin
                build_frame[0] = `LMC_CODE_BUS;
                build_frame[1] = cmd_i.bus;
                build_frame[2] = `LMC_CR;
                build_last     = 4'h2;
                build_reply    = 1'b0;
                build_ok       = cmd_i.bus <= `LMC_BUS_LAST;
            end
            lmc_pkg::LMC_OP_ADDR: begin
                build_frame[0] = `LMC_CODE_ADDR;
                build_frame[1] = {1'b0, cmd_i.addr};
                build_frame[2] = `LMC_CR;
                build_last     = 4'h2;
                build_reply    = 1'b0;
                build_ok       = cmd_i.addr >= `LMC_ADDR_FIRST;
            end
            default: build_ok = 1'b0;
        endcase
    end

    // A reply counts only if code and length match the request, plus the selector
    // for a setup read, since the board may still hold an older reply
    wire accept   = (state_reg == ST_IDLE) && cmd_valid_i;
    wire tx_fire  = tx_valid_reg && tx_ready_i;
    wire tx_end   = tx_fire && (tx_idx_reg == tx_last_reg);
    wire rx_match = rx_done && (rx_frame[0] == exp_code_reg)
                  && (rx_len == exp_len_reg)
                  && ((exp_code_reg != `LMC_CODE_SETUP_RD)
                      || (rx_frame[1] == exp_motor_reg));
    wire timed_out = wait_cnt_reg >= TIMEOUT_CYC;
    wire [3:0] tx_idx_next = tx_idx_reg + 4'h1;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg     <= ST_IDLE;
            tx_buf_reg    <= '0;
            tx_last_reg   <= 4'h0;
            tx_idx_reg    <= 4'h0;
            tx_data_reg   <= 8'h00;
            tx_valid_reg  <= 1'b0;
            expect_reg    <= 1'b0;
            exp_code_reg  <= 8'h00;
            exp_len_reg   <= 4'h0;
            exp_motor_reg <= 8'h00;
            wait_cnt_reg  <= 32'h0;
            done_reg      <= 1'b0;
            err_reg       <= 1'b0;
            ready_reg     <= 1'b1;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept && !build_ok) begin
                        done_reg <= 1'b1;
                        err_reg  <= 1'b1;
                    end else if (accept) begin
                        tx_buf_reg    <= build_frame;
                        tx_last_reg   <= build_last;
                        tx_idx_reg    <= 4'h0;
                        tx_data_reg   <= build_frame[0];
                        tx_valid_reg  <= 1'b1;
                        expect_reg    <= build_reply;
                        exp_code_reg  <= build_code;
                        exp_len_reg   <= build_len;
                        exp_motor_reg <= cmd_i.motor;
                        err_reg       <= 1'b0;
                        ready_reg     <= 1'b0;
                        state_reg     <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_end) begin
                        tx_valid_reg <= 1'b0;
                        wait_cnt_reg <= 32'h0;
                        if (expect_reg) begin
                            state_reg <= ST_WAIT;
                        end else begin
                            // Board restarts silently after these
                            done_reg  <= 1'b1;
                            ready_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end else if (tx_fire) begin
                        tx_idx_reg  <= tx_idx_next;
                        tx_data_reg <= tx_buf_reg[tx_idx_next];
                    end
                end
                ST_WAIT: begin
                    wait_cnt_reg <= wait_cnt_reg + 32'h1;
                    if (rx_match || timed_out) begin
                        done_reg  <= 1'b1;
                        err_reg   <= !rx_match;
                        ready_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Reply fields and the speed limits shadowed per motor
    wire got_setup = (state_reg == ST_WAIT) && rx_match
                   && (exp_code_reg == `LMC_CODE_SETUP_RD);
    wire got_wr    = (state_reg == ST_WAIT) && rx_match
                   && (exp_code_reg == `LMC_CODE_SETUP_WR);
    wire wr_ok     = got_wr && (rx_frame[1] == `LMC_STATUS_OK)
                   && sel_ok(exp_motor_reg);
    wire [15:0] rd_min = {rx_frame[7], rx_frame[8]};
    wire [15:0] rd_max = {rx_frame[9], rx_frame[10]};
    wire [15:0] wr_min = {tx_buf_reg[7], tx_buf_reg[8]};
    wire [15:0] wr_max = {tx_buf_reg[9], tx_buf_reg[10]};
    wire [1:0]  sp_idx = sel_idx(speed_motor_i);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            version_reg   <= 40'h0;
            ident_reg     <= 48'h0;
            setup_reg     <= '0;
            wr_status_reg <= 8'h00;
            speed_ok_reg  <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                min_reg[i] <= 16'h0000;
                max_reg[i] <= 16'h0000;
            end
        end else begin
            if ((state_reg == ST_WAIT) && rx_match) begin
                if (exp_code_reg == `LMC_CODE_VERSION) begin
                    version_reg <= {rx_frame[1], rx_frame[2], rx_frame[3],
                                    rx_frame[4], rx_frame[5]};
                end
                if (exp_code_reg == `LMC_CODE_IDENT) begin
                    ident_reg <= {rx_frame[1], rx_frame[2], rx_frame[3],
                                  rx_frame[4], rx_frame[5],
                                  rx_frame[6]};
                end
            end
            if (got_setup) begin
                setup_reg <= {rx_frame[2], rx_frame[3], rx_frame[4],
                              rx_frame[5], rx_frame[6], rd_min,
                              rd_max};
                min_reg[sel_idx(exp_motor_reg)] <= rd_min;
                max_reg[sel_idx(exp_motor_reg)] <= rd_max;
            end
            if (got_wr) begin
                wr_status_reg <= rx_frame[1];
            end
            if (wr_ok) begin
                min_reg[sel_idx(exp_motor_reg)] <= wr_min;
                max_reg[sel_idx(exp_motor_reg)] <= wr_max;
            end
            // Limits are only as fresh as the last setup read or write
            speed_ok_reg <= sel_ok(speed_motor_i)
                          && (speed_i >= min_reg[sp_idx])
                          && (speed_i <= max_reg[sp_idx]);
        end
    end

    assign cmd_ready_o           = ready_reg;
    assign done_o                = done_reg;
    assign err_o                 = err_reg;
    assign version_o             = version_reg;
    assign board_identity_byte_o = ident_reg;
    assign setup_o               = setup_reg;
    assign wr_status_o           = wr_status_reg;
    assign speed_ok_o            = speed_ok_reg;
    assign tx_data_o             = tx_data_reg;
    assign tx_valid_o            = tx_valid_reg;

endmodule

/* lmc_host_checker.sv */
// Port-level properties of the lens motor command controller
`include "lmc_cfg.svh"
module lmc_host_checker (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    input  wire logic          cmd_valid_i,
    input  lmc_pkg::lmc_cmd_t  cmd_i,
    input  wire logic          cmd_ready_o,
    input  wire logic          done_o,
    input  wire logic          err_o,
    input  wire logic [39:0]   version_o,
    input  lmc_pkg::lmc_setup_t setup_o,
    input  wire logic [7:0]    tx_data_o,
    input  wire logic          tx_valid_o,
    input  wire logic          tx_ready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire              take = cmd_valid_i && cmd_ready_o;
    lmc_pkg::lmc_op_t op;
    assign op = cmd_i.op;

    version_code_a:
    assert property (take && op == lmc_pkg::LMC_OP_VERSION
        |=> tx_valid_o && tx_data_o == `LMC_CODE_VERSION)
        else $error("wrong version request byte");
    ident_code_a:
    assert property (take && op == lmc_pkg::LMC_OP_IDENT
        |=> tx_valid_o && tx_data_o == `LMC_CODE_IDENT)
        else $error("wrong identity request byte");
    write_code_a:
    assert property (take && op == lmc_pkg::LMC_OP_SETUP_WR
        |=> tx_valid_o && tx_data_o == `LMC_CODE_SETUP_WR)
        else $error("wrong setup write byte");
    read_refuse_a:
    assert property (take && op == lmc_pkg::LMC_OP_SETUP_RD
        && (cmd_i.motor < 8'h01 || cmd_i.motor > 8'h04)
        |=> done_o && err_o && !tx_valid_o)
        else $error("bad motor selector not refused");
    bus_refuse_a:
    assert property (take && op == lmc_pkg::LMC_OP_BUS && cmd_i.bus > 8'h02
        |=> done_o && err_o && !tx_valid_o)
        else $error("bad bus selector not refused");
    addr_refuse_a:
    assert property (take && op == lmc_pkg::LMC_OP_ADDR && cmd_i.addr == 7'h00
        |=> done_o && err_o && !tx_valid_o)
        else $error("zero address not refused");
    tx_hold_a:
    assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte changed before taken");
    bus_quiet_a:
    assert property (take && op == lmc_pkg::LMC_OP_BUS && cmd_i.bus <= 8'h02
        |-> ##[2:100] (done_o && !err_o))
        else $error("bus switch not finished");
    version_upd_a:
    assert property ($changed(version_o) |-> done_o && !err_o)
        else $error("version changed outside completion");
    setup_upd_a:
    assert property ($changed(setup_o) |-> done_o && !err_o)
        else $error("setup changed outside completion");

    cover property (done_o && !err_o && $changed(version_o));
    cover property (take && op == lmc_pkg::LMC_OP_SETUP_WR);
    cover property (take && op == lmc_pkg::LMC_OP_BUS);
endmodule

bind lmc_host lmc_host_checker u_checker (.*);

/* lmc_host_test.sv */
// Self-checking bench for the lens motor command controller
`include "lmc_cfg.svh"
module lmc_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [39:0] VER   = 40'h1122334455;  // Arbitrary value
    localparam logic [47:0] IDENT = 48'h6A7B8C9DAEBF; // Arbitrary value
    logic                clk_i = 1'b0;
    logic                nrst_i = 1'b0;
    logic                cmd_valid_i = 1'b0;
    lmc_pkg::lmc_cmd_t   cmd_i = '0;
    logic [7:0]          speed_motor_i = 8'h01;
    logic [15:0]         speed_i = 16'h0000;
    logic                slow = 1'b0;
    logic                mute = 1'b0;
    logic                cmd_ready_o, done_o, err_o, speed_ok_o;
    logic [39:0]         version_o;
    logic [47:0]         board_identity_byte_o;
    lmc_pkg::lmc_setup_t setup_o;
    logic [7:0]          wr_status_o, tx_data_o, rx_data_i;
    logic                tx_valid_o, tx_ready_i, rx_valid_i;
    logic [7:0]          last_code, last_bus, last_addr;
    logic [3:0]          last_len;
    int                  mismatches = 0;
    int                  checks = 0;
    lmc_pkg::lmc_setup_t wr_setup = {8'h00, 8'h00, 8'h01, 16'h1234,
                                     16'h0064, 16'h0200};

    lmc_host #(.TIMEOUT_CYC(200)) u_dut (.*);
    lmc_board_model #(.VER(VER), .IDENT(IDENT)) u_board (
        .clk_i(clk_i), .nrst_i(nrst_i), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .slow_i(slow), .mute_i(mute),
        .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
        .rx_valid_o(rx_valid_i), .last_code_o(last_code),
        .last_len_o(last_len), .last_bus_o(last_bus),
        .last_addr_o(last_addr));

    initial forever #50 clk_i = ~clk_i;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic lmc_pkg::lmc_setup_t dflt(input int m);
        return {(m == 4) ? 8'h01 : 8'h00, 8'h01, 8'h01, 16'(m * 100),
                16'h000A, 16'h01F4};
    endfunction

    task automatic run(input lmc_pkg::lmc_op_t op, input logic [7:0] motor,
                       input logic [7:0] arg);
        int n;
        @(negedge clk_i);
        cmd_i = '{op, motor, wr_setup, arg, arg[6:0]};
        cmd_valid_i = 1'b1;
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        n = 0;
        // Bounded wait so a lost completion cannot hang the run
        while (done_o !== 1'b1 && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        check({n < 2000, cmd_ready_o}, 2'b11);
    endtask

    task automatic t_ids();
        slow = 1'b1;
        run(lmc_pkg::LMC_OP_VERSION, 8'h00, 8'h00);
        check({err_o, last_code, last_len}, {1'b0, 8'h76, 4'h1});
        check(version_o, VER);
        run(lmc_pkg::LMC_OP_IDENT, 8'h00, 8'h00);
        check({err_o, last_code, last_len}, {1'b0, 8'h79, 4'h1});
        check(board_identity_byte_o, IDENT);
        slow = 1'b0;
    endtask

    task automatic t_read();
        for (int m = 1; m <= 4; m++) begin
            run(lmc_pkg::LMC_OP_SETUP_RD, 8'(m), 8'h00);
            check({last_code, last_len}, {8'h67, 4'h2});
            check(setup_o, dflt(m));
            check(setup_o.motor_type, (m == 4) ? 8'h01 : 8'h00);
            check({setup_o.left_stop, setup_o.right_stop}, 16'h0101);
            check(setup_o.steps, 16'(m * 100));
        end
        run(lmc_pkg::LMC_OP_SETUP_RD, 8'h00, 8'h00);
        check(err_o, 1'b1);
        run(lmc_pkg::LMC_OP_SETUP_RD, 8'h05, 8'h00);
        check(err_o, 1'b1);
    endtask

    task automatic t_write();
        logic [15:0] sp [4] = '{16'h0063, 16'h0064, 16'h0200, 16'h0201};
        run(lmc_pkg::LMC_OP_SETUP_WR, 8'h02, 8'h00);
        check({last_len, wr_status_o}, {4'hB, 8'h00});
        run(lmc_pkg::LMC_OP_SETUP_RD, 8'h02, 8'h00);
        check(setup_o, wr_setup);
        speed_motor_i = 8'h02;
        for (int i = 0; i < 4; i++) begin
            speed_i = sp[i];
            repeat (2) @(negedge clk_i);
            check(speed_ok_o, i == 1 || i == 2);
        end
        run(lmc_pkg::LMC_OP_SETUP_WR, 8'h05, 8'h00);
        check(wr_status_o, 8'h01);
    endtask

    task automatic t_bus_addr();
        slow = 1'b1;
        for (int b = 0; b <= 2; b++) begin
            run(lmc_pkg::LMC_OP_BUS, 8'h00, 8'(b));
            check({err_o, last_bus, last_len}, {1'b0, 8'(b), 4'h2});
        end
        slow = 1'b0;
        run(lmc_pkg::LMC_OP_BUS, 8'h00, 8'h03);
        check(err_o, 1'b1);
        run(lmc_pkg::LMC_OP_ADDR, 8'h00, 8'h10);
        check({err_o, last_code, last_addr}, {1'b0, 8'h41, 8'h10});
        run(lmc_pkg::LMC_OP_ADDR, 8'h00, 8'h7F);
        check(last_addr, 8'h7F);
        run(lmc_pkg::LMC_OP_ADDR, 8'h00, 8'h00);
        check({err_o, last_addr}, {1'b1, 8'h7F});
        run(lmc_pkg::LMC_OP_BUS, 8'h00, 8'h02);
        check({err_o, last_bus}, {1'b0, 8'h02});
    endtask

    task automatic t_silent();
        mute = 1'b1;
        run(lmc_pkg::LMC_OP_VERSION, 8'h00, 8'h00);
        check({err_o, version_o}, {1'b1, VER});
        mute = 1'b0;
        run(lmc_pkg::LMC_OP_VERSION, 8'h00, 8'h00);
        check({err_o, version_o}, {1'b0, VER});
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        t_ids();
        t_read();
        t_write();
        t_bus_addr();
        t_silent();
        complete_run();
    end
endmodule

/* lmc_pkg.sv */
// Types shared by the lens motor command controller
package lmc_pkg;

    typedef enum logic [2:0] {
        LMC_OP_VERSION,
        LMC_OP_IDENT,
        LMC_OP_SETUP_RD,
        LMC_OP_SETUP_WR,
        LMC_OP_BUS,
        LMC_OP_ADDR
    } lmc_op_t;

    typedef struct packed {
        logic [7:0]  motor_type;
        logic [7:0]  left_stop;
        logic [7:0]  right_stop;
        logic [15:0] steps;
        logic [15:0] speed_min;
        logic [15:0] speed_max;
    } lmc_setup_t;

    typedef struct packed {
        lmc_op_t    op;
        logic [7:0] motor;
        lmc_setup_t setup;
        logic [7:0] bus;
        logic [6:0] addr;
    } lmc_cmd_t;

    typedef logic [11:0][7:0] lmc_frame_t;

endpackage
